// file: stedg_core.sv
// scan target edge digitizer: digital-mode edge capture and tv-mode raster.
// assumes comparator, trigger and buttons are asynchronous pins; the memory
// controller drains edge words and per-line counts over valid/ready.
// Notes on behaviour
// - digital scan is 512 lines of 512
// - comparator high means written trace present
// - digitize request starts at next trigger
// - vertical counter steps 0 to 511
// - sample comparator on every counter step
// - on change store complemented count
// - tv raster interlaced 525 or 625 lines
// - two-level video high when written or overlaid
// - overlay scale characters on both videos
// - horizontal counter addresses per-line point count
// - at most 30 values, kept in pairs
// - 511 is top, zero is bottom
module stedg_core
  import stedg_pkg::*;
#(
  parameter int DIV = STEDG_DIV_DEFAULT
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        comp_in,
  input  wire logic        trigger_in,
  input  wire logic        local_digitize,
  input  wire logic        remote_digitize,
  input  wire logic        tv_mode,
  input  wire logic        opt_625,
  input  wire logic        char_pixel,
  input  wire logic        analog_video_in,
  output logic             two_level_video_out,
  output logic             analog_replica_video_out,
  output logic             overlay_active,
  output logic [8:0]       char_col,
  output logic [9:0]       char_row,
  output logic             edge_valid,
  input  wire logic        edge_ready,
  output logic [8:0]       edge_value,
  output logic             count_valid,
  output logic [8:0]       count_line,
  output logic [4:0]       count_points,
  output logic             busy
);
  initial begin
    if (DIV < 1 || DIV > 255) $error("DIV out of range");
  end

  // two-flop synchronisers for every pin
  logic [1:0] comp_s_q, trig_s_q, loc_s_q, rem_s_q, tv_s_q, opt_s_q, chr_s_q, ana_s_q;
  logic       trig_old_q, req_old_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      comp_s_q   <= '0;
      trig_s_q   <= '0;
      loc_s_q    <= '0;
      rem_s_q    <= '0;
      tv_s_q     <= '0;
      opt_s_q    <= '0;
      chr_s_q    <= '0;
      ana_s_q    <= '0;
      trig_old_q <= 1'b0;
      req_old_q  <= 1'b0;
    end else begin
      comp_s_q   <= {comp_s_q[0], comp_in};
      trig_s_q   <= {trig_s_q[0], trigger_in};
      loc_s_q    <= {loc_s_q[0], local_digitize};
      rem_s_q    <= {rem_s_q[0], remote_digitize};
      tv_s_q     <= {tv_s_q[0], tv_mode};
      opt_s_q    <= {opt_s_q[0], opt_625};
      chr_s_q    <= {chr_s_q[0], char_pixel};
      ana_s_q    <= {ana_s_q[0], analog_video_in};
      trig_old_q <= trig_s_q[1];
      req_old_q  <= loc_s_q[1] | rem_s_q[1];
    end
  end
  logic comp, trig_rise, req_rise;
  assign comp      = comp_s_q[1];
  assign trig_rise = trig_s_q[1] & ~trig_old_q;
  assign req_rise  = (loc_s_q[1] | rem_s_q[1]) & ~req_old_q;

  // beam step enable from a divider; the tube cannot follow the full clock
  logic [7:0] div_q, div_d;
  logic       step;
  assign step = div_q == 8'(DIV - 1);
  always_comb div_d = step ? 8'h00 : div_q + 8'h01;

  stedg_state_t st_q, st_d;
  logic [8:0] vcnt_q, vcnt_d, hcnt_q, hcnt_d;
  logic       prev_q, prev_d;
  logic [4:0] npts_q, npts_d;
  logic       pend_q, pend_d;
  logic       cv_q, cv_d;
  logic [8:0] cl_q, cl_d;
  logic [4:0] cp_q, cp_d;
  logic [9:0] tvl_q, tvl_d;
  logic       fld_q, fld_d;
  logic       bin_q, bin_d, ana_q, ana_d, ov_q, ov_d;
  logic       f_valid, f_ready;
  logic [8:0] f_data;

  function automatic logic [8:0] stedg_compl(input logic [8:0] v);
    return ~v;
  endfunction : stedg_compl

  logic [9:0] tv_last;
  logic       stall, edge_now, room;
  assign tv_last  = opt_s_q[1] ? STEDG_TVL_B_LAST : STEDG_TVL_A_LAST;
  assign edge_now = step && (st_q == STEDG_SCAN) && (comp != prev_q);
  // refuse a top edge unless its bottom partner also fits
  assign room     = prev_q ? 1'b1 : (npts_q <= STEDG_EDGE_LIMIT - 5'h02);
  // stall the beam rather than drop an edge, or overwrite an unread line count,
  // when the memory side backs up
  assign stall    = (st_q == STEDG_SCAN) &&
                    (!f_ready || (cv_q && !edge_ready && (vcnt_q == STEDG_CNT_LAST)));
  assign f_valid  = edge_now && room && !stall;
  assign f_data   = stedg_compl(vcnt_q);

  always_comb begin
    st_d = st_q; vcnt_d = vcnt_q; hcnt_d = hcnt_q; prev_d = prev_q;
    npts_d = npts_q; pend_d = pend_q | req_rise;
    cv_d = cv_q & ~edge_ready; cl_d = cl_q; cp_d = cp_q;
    tvl_d = tvl_q; fld_d = fld_q;
    bin_d = 1'b0; ana_d = 1'b0; ov_d = 1'b0;
    unique case (st_q)
      STEDG_IDLE: begin
        if (tv_s_q[1]) st_d = STEDG_TV;
        else if (pend_q) st_d = STEDG_ARM;
      end
      STEDG_ARM: begin
        if (trig_rise) begin
          // a request landing with the trigger waits for the next scan
          st_d = STEDG_SCAN; pend_d = req_rise;
          vcnt_d = STEDG_CNT_ZERO; hcnt_d = STEDG_CNT_ZERO;
          prev_d = STEDG_NOT_WRITTEN; npts_d = '0;
        end
      end
      STEDG_SCAN: begin
        if (step && !stall) begin
          if (f_valid) begin
            prev_d = comp; npts_d = npts_q + 5'h01;
          end
          if (vcnt_q == STEDG_CNT_LAST) begin
            // close an open trace at the bottom so pairs stay whole
            cv_d = 1'b1; cl_d = hcnt_q;
            cp_d = npts_d + {4'h0, prev_d};
            prev_d = STEDG_NOT_WRITTEN; npts_d = '0;
            vcnt_d = STEDG_CNT_ZERO;
            if (hcnt_q == STEDG_CNT_LAST) st_d = STEDG_IDLE;
            else hcnt_d = hcnt_q + 9'h001;
          end else begin
            vcnt_d = vcnt_q + 9'h001;
          end
        end
      end
      STEDG_TV: begin
        if (!tv_s_q[1]) st_d = STEDG_IDLE;
        else if (step) begin
          ov_d  = chr_s_q[1] && (tvl_q[9:3] == 7'h00);
          bin_d = comp | ov_d;
          ana_d = ana_s_q[1] | ov_d;
          if (hcnt_q == STEDG_TVP_LAST) begin
            hcnt_d = STEDG_CNT_ZERO;
            // interlace: each field takes every other line
            if (tvl_q >= tv_last - 10'h001) begin
              fld_d = ~fld_q; tvl_d = {9'h000, ~fld_q};
            end else tvl_d = tvl_q + 10'h002;
          end else hcnt_d = hcnt_q + 9'h001;
        end else begin
          bin_d = bin_q; ana_d = ana_q; ov_d = ov_q;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_q <= '0; st_q <= STEDG_IDLE; vcnt_q <= '0; hcnt_q <= '0;
      prev_q <= STEDG_NOT_WRITTEN; npts_q <= '0; pend_q <= 1'b0;
      cv_q <= 1'b0; cl_q <= '0; cp_q <= '0; tvl_q <= '0; fld_q <= 1'b0;
      bin_q <= 1'b0; ana_q <= 1'b0; ov_q <= 1'b0;
    end else begin
      div_q <= (st_q == STEDG_SCAN && stall) ? div_q : div_d;
      st_q <= st_d; vcnt_q <= vcnt_d; hcnt_q <= hcnt_d;
      prev_q <= prev_d; npts_q <= npts_d; pend_q <= pend_d;
      cv_q <= cv_d; cl_q <= cl_d; cp_q <= cp_d; tvl_q <= tvl_d; fld_q <= fld_d;
      bin_q <= bin_d; ana_q <= ana_d; ov_q <= ov_d;
    end
  end

  logic       fo_valid;
  logic [8:0] fo_data;
  logic       ev_q, ev_d;
  logic [8:0] evl_q, evl_d;
  stedg_fifo #(.WIDTH(STEDG_CW), .DEPTH(STEDG_FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (fo_valid),
    .out_ready (!ev_q || edge_ready),
    .out_data  (fo_data)
  );
  always_comb begin
    ev_d  = ev_q; evl_d = evl_q;
    if (!ev_q || edge_ready) begin
      ev_d = fo_valid; evl_d = fo_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ev_q <= 1'b0; evl_q <= '0;
    end else begin
      ev_q <= ev_d; evl_q <= evl_d;
    end
  end

  assign edge_valid               = ev_q;
  assign edge_value               = evl_q;
  assign count_valid              = cv_q;
  assign count_line               = cl_q;
  assign count_points             = cp_q;
  assign two_level_video_out      = bin_q;
  assign analog_replica_video_out = ana_q;
  assign overlay_active           = ov_q;
  assign char_col                 = hcnt_q;
  assign char_row                 = tvl_q;
  assign busy                     = st_q[2];
endmodule : stedg_core

// file: stedg_pkg.sv
// package for the scan target edge digitizer: sizes, modes, states.
// assumes a single 250 MHz clock domain and synchronous active-low reset.
package stedg_pkg;
  localparam int          STEDG_LINES       = 512;
  localparam int          STEDG_POINTS      = 512;
  localparam int          STEDG_CW          = 9;
  localparam logic [8:0]  STEDG_CNT_LAST    = 9'h1FF;
  localparam logic [8:0]  STEDG_CNT_ZERO    = 9'h000;
  localparam int          STEDG_MAX_EDGES   = 30;
  localparam logic [4:0]  STEDG_EDGE_LIMIT  = 5'h1E;
  localparam int          STEDG_TV_LINES_A  = 525;
  localparam int          STEDG_TV_LINES_B  = 625;
  localparam logic [9:0]  STEDG_TVL_A_LAST  = 10'h20C;
  localparam logic [9:0]  STEDG_TVL_B_LAST  = 10'h270;
  localparam int          STEDG_TV_PIXELS   = 512;
  localparam logic [8:0]  STEDG_TVP_LAST    = 9'h1FF;
  localparam int          STEDG_FIFO_DEPTH  = 16;
  localparam int          STEDG_DIV_DEFAULT = 4;
  localparam logic        STEDG_NOT_WRITTEN = 1'b0;
  localparam logic [2:0]  STEDG_CHAR_ROWS   = 3'h7;

  typedef enum logic [3:0] {
    STEDG_IDLE = 4'b0001,
    STEDG_ARM  = 4'b0010,
    STEDG_SCAN = 4'b0100,
    STEDG_TV   = 4'b1000
  } stedg_state_t;
endpackage : stedg_pkg

// file: stedg_fifo.sv
// fifo of flip-flops with valid/ready on both sides.
// assumes write and read in the same clock domain.
module stedg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic             push, pop;

  assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem_q[rp_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule : stedg_fifo

// file: stedg_core_chk.sv
// checker for the edge digitizer core, bound to the core's ports.
// assumes one clock domain and pin inputs that pass a two-flop synchroniser.
module stedg_core_chk
  import stedg_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       comp_in,
  input wire logic       trigger_in,
  input wire logic       tv_mode,
  input wire logic       char_pixel,
  input wire logic       two_level_video_out,
  input wire logic       overlay_active,
  input wire logic [9:0] char_row,
  input wire logic       edge_valid,
  input wire logic       edge_ready,
  input wire logic [8:0] edge_value,
  input wire logic       count_valid,
  input wire logic [8:0] count_line,
  input wire logic [4:0] count_points,
  input wire logic       busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // eight quiet cycles cover synchroniser plus output register
  sequence s_quiet;
    (tv_mode && !comp_in && !char_pixel) [*8];
  endsequence
  sequence s_trig_seen;
    $past(trigger_in, 3) || $past(trigger_in, 4) || $past(trigger_in, 5);
  endsequence
  rst_idle_a: assert property ($rose(rst_n) |-> !busy && !edge_valid && !count_valid)
    else $error("outputs busy after reset");
  trig_start_a: assert property ($rose(busy) |-> s_trig_seen)
    else $error("scan started without trigger");
  edge_hold_a: assert property (edge_valid && !edge_ready |=> edge_valid && $stable(edge_value))
    else $error("edge word dropped while stalled");
  count_hold_a: assert property (count_valid && !edge_ready |=> count_valid && $stable(count_points))
    else $error("line count dropped while stalled");
  edge_limit_a: assert property (count_valid |-> count_points <= STEDG_EDGE_LIMIT)
    else $error("too many points in a line");
  pair_count_a: assert property (count_valid |-> !count_points[0])
    else $error("odd point count");
  video_quiet_a: assert property (s_quiet |-> !two_level_video_out)
    else $error("video high with nothing written");
  overlay_row_a: assert property (tv_mode && overlay_active |-> $past(char_row) < 10'h008)
    else $error("overlay outside character rows");
  row_range_a: assert property (char_row <= STEDG_TVL_B_LAST)
    else $error("raster line out of range");
endmodule : stedg_core_chk

bind stedg_core stedg_core_chk i_chk (
  .sys_clk, .rst_n, .comp_in, .trigger_in, .tv_mode, .char_pixel, .two_level_video_out,
  .overlay_active, .char_row, .edge_valid, .edge_ready, .edge_value, .count_valid,
  .count_line, .count_points, .busy
);

// file: stedg_partner.sv
// target comparator and edge sink model facing the digitizer core.
// assumes DIV of 1, so its line timer wraps with the core's lines when unstalled.
module stedg_partner (
  input  wire logic       sys_clk,
  input  wire logic       busy,
  input  wire logic [1:0] mode,
  input  wire logic       stall,
  output logic            comp_in = 1'b0,
  output logic            edge_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] t_q = 9'h000;
  always @(posedge sys_clk) begin
    t_q <= busy ? t_q + 9'h001 : 9'h000;
    edge_ready <= !stall;
    case (mode)
      2'h1: comp_in <= (t_q >= 9'h064 && t_q < 9'h0C8) || (t_q >= 9'h12C && t_q < 9'h140);
      2'h2: comp_in <= t_q[3];
      2'h3: comp_in <= 1'b1;
      default: comp_in <= 1'b0;
    endcase
  end
endmodule : stedg_partner

// file: test_scan_target_edge_digitizer.sv
// self-checking bench for the edge digitizer core with its comparator and sink.
// assumes DIV of 1; only the first lines of each scan are watched, reset ends a scan.
module test_scan_target_edge_digitizer
  import stedg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, rst_n, comp_in, trigger_in, local_digitize, remote_digitize;
  logic        tv_mode, opt_625, char_pixel, analog_video_in, two_level_video_out;
  logic        overlay_active, edge_valid, edge_ready, count_valid, busy, stall;
  logic        analog_replica_video_out;
  logic [8:0]  char_col, edge_value, count_line;
  logic [9:0]  char_row;
  logic [4:0]  count_points;
  logic [1:0]  mode;
  logic [31:0] lf;
  int          errors, n_compared, line_n;
  logic [8:0]  q[$];
  logic        ovl_en;
  logic [2:0]  cp_h, av_h;
  logic [8:0]  col_prev;
  int          n;

  stedg_core #(.DIV(1)) i_dut (
    .sys_clk, .rst_n, .comp_in, .trigger_in, .local_digitize, .remote_digitize, .tv_mode,
    .opt_625, .char_pixel, .analog_video_in, .two_level_video_out, .analog_replica_video_out,
    .overlay_active, .char_col, .char_row, .edge_valid, .edge_ready, .edge_value,
    .count_valid, .count_line, .count_points, .busy
  );
  stedg_partner i_far (.sys_clk, .busy, .mode, .stall, .comp_in, .edge_ready);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // heavy sink stalls in the dense mode back up edge words without filling the fifo
  always @(posedge sys_clk) begin
    lf <= lfsr_next(lf);
    stall <= (mode == 2'h2) ? (lf[1] | lf[2]) : (lf[1] & lf[2]);
    analog_video_in <= lf[3];
    char_pixel <= (tv_mode && !ovl_en) ? 1'b0 : lf[4];
    // pin history: the core shows a pin three edges after it is sampled
    cp_h <= {cp_h[1:0], char_pixel};
    av_h <= {av_h[1:0], analog_video_in};
  end

  // reference model: edge words queue up per line and are judged at the line count
  always @(posedge sys_clk) begin
    if (rst_n && edge_valid && edge_ready) q.push_back(edge_value);
    if (rst_n && count_valid && edge_ready) begin
      chk("count_line", count_line, line_n[8:0]);
      if (mode == 2'h0) chk("points", count_points, 0);
      if (mode == 2'h2) chk("points", count_points, STEDG_EDGE_LIMIT);
      if (mode == 2'h3) chk("top_word", q[0], STEDG_CNT_LAST);
      if (mode == 2'h3) chk("words", q.size(), 1);
      if (mode == 2'h1) begin
        chk("points", count_points, 4);
        chk("words", q.size(), 4);
        chk("top_word", q[0] > 9'h193 && q[0] < 9'h1A3, 1);
        chk("order", q[0] > q[1] && q[1] > q[2] && q[2] > q[3], 1);
      end
      q.delete();
      line_n++;
    end
  end

  task automatic run_scan(input logic [1:0] m);
    int k;
    mode <= m;
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 2; k++) begin
      repeat (4) @(posedge sys_clk);
      trigger_in <= 1'b1;
      repeat (8) @(posedge sys_clk);
      trigger_in <= 1'b0;
      local_digitize <= m[0] && k == 1;
      remote_digitize <= !m[0] && k == 1;
      repeat (12) @(posedge sys_clk);
      local_digitize <= 1'b0;
      remote_digitize <= 1'b0;
      chk("busy_before_trigger", busy, 0);
    end
    q.delete();
    line_n = 0;
    trigger_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    trigger_in <= 1'b0;
    for (k = 0; k < 20000 && line_n < 3; k++) @(posedge sys_clk);
    chk("lines_done", line_n >= 3, 1);
  endtask : run_scan

  initial begin
    {rst_n, trigger_in, local_digitize, remote_digitize, tv_mode, opt_625} = 6'h00;
    {char_pixel, analog_video_in, stall, mode} = 5'h00;
    ovl_en = 1'b0;
    lf = 32'h00017263;
    run_scan(2'h3);
    run_scan(2'h1);
    run_scan(2'h2);
    run_scan(2'h0);
    // a digital scan runs far longer than the bench; reset ends it before tv mode
    rst_n <= 1'b0;
    tv_mode <= 1'b1;
    opt_625 <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk("video_blank", two_level_video_out, 0);
    mode <= 2'h3;
    repeat (12) @(posedge sys_clk);
    chk("video_written", two_level_video_out, 1);
    ovl_en <= 1'b1;
    mode <= 2'h0;
    repeat (8) @(posedge sys_clk);
    col_prev = char_col;
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk);
      chk("overlay", overlay_active, cp_h[2]);
      chk("video_ovl", two_level_video_out, cp_h[2]);
      chk("analog_ovl", analog_replica_video_out, av_h[2] | cp_h[2]);
      chk("col_step", char_col, col_prev + 9'h001);
      chk("row", char_row, 0);
      col_prev = char_col;
    end
    print_verdict();
  end

  initial begin
    #200us;
    errors++;
    print_verdict();
  end
endmodule : test_scan_target_edge_digitizer
